// ### brake_seq_pkg.sv
// Summary of operation
// R1: servo ready stays low while main supply is absent.
// R2: servo ready rises about 1.5 s after main supply comes up.
// R3: enable request is ignored until servo ready is high.
// R4: active enable request turns the power stage on, motor excited.
// R5: inactive request or alarm turns the power stage off, motor free.
// R6: control supply must come no later than main supply.
// R7: motor is stationary below standstill threshold, 0 to 1000 r/min, default 5.
// R8: stationary stop holds current, applies brake, frees after hold time, default 150 ms.
// R9: brake releases brake_open_delay after current on, 0 to 1000 ms, default 0.
// R10: running stop cuts current at once and keeps brake released.
// R11: running brake applies at wait limit or at running brake speed, whichever first.
// R12: running brake speed setting spans 0 to 3000 r/min, default 100.
// R13: brake output high releases the brake relay, low applies it.
// R14: speed above threshold at enable removal selects the running sequence.
// R15: all delays count a one millisecond tick, restarted at sequence start; for the ready delay the code clears only the ms count, the tick runs free.
// R16: alarm while enabled chooses stop sequence like enable removal; the code does so only above standstill threshold, else frees the motor at once.
package brake_seq_pkg;
	localparam int CLK_HZ = 40000000;
	localparam int TICK_CYCLES = CLK_HZ / 1000;
	localparam int READY_DELAY_MS = 1500;
	localparam logic [15:0] STANDSTILL_SPEED_DEF = 16'h0005;
	localparam logic [15:0] HOLD_TIME_DEF = 16'h0096;
	localparam logic [15:0] WAIT_LIMIT_DEF = 16'h0000;
	localparam logic [15:0] RUN_BRAKE_SPEED_DEF = 16'h0064;
	localparam logic [15:0] OPEN_DELAY_DEF = 16'h0000;
	localparam logic [15:0] STANDSTILL_SPEED_MAX = 16'h03e8;
	localparam logic [15:0] HOLD_TIME_MAX = 16'h07d0;
	localparam logic [15:0] WAIT_LIMIT_MAX = 16'h07d0;
	localparam logic [15:0] RUN_BRAKE_SPEED_MAX = 16'h0bb8;
	localparam logic [15:0] OPEN_DELAY_MAX = 16'h03e8;
	localparam logic [7:0] ADR_STANDSTILL = 8'h00;
	localparam logic [7:0] ADR_HOLD = 8'h04;
	localparam logic [7:0] ADR_WAIT = 8'h08;
	localparam logic [7:0] ADR_RUNSPD = 8'h0c;
	localparam logic [7:0] ADR_OPEN = 8'h10;
	localparam logic [7:0] ADR_STATUS = 8'h14;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_READY = 3'b001,
		ST_ON = 3'b011,
		ST_HOLD = 3'b010,
		ST_COAST = 3'b110
	} seq_state_t;

	typedef struct packed {
		logic [15:0] standstill_speed_threshold;
		logic [15:0] standstill_brake_hold_time;
		logic [15:0] running_brake_wait_limit;
		logic [15:0] running_brake_speed;
		logic [15:0] brake_open_delay;
	} cfg_t;

	typedef struct packed {
		cfg_t cfg;
		seq_state_t state;
		logic [15:0] tick_cnt;
		logic [15:0] ms_cnt;
		logic servo_ready;
		logic power_on;
		logic brake_release;
		logic ack;
		logic [31:0] rdata;
	} state_t;
endpackage : brake_seq_pkg

// ### servo_enable_brake_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module servo_enable_brake_sequencer #(
	parameter int TICK_CYCLES = brake_seq_pkg::TICK_CYCLES,
	parameter int READY_DELAY_MS = brake_seq_pkg::READY_DELAY_MS
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic main_supply_in,
	input wire logic servo_enable_request_in,
	input wire logic alarm_in,
	input wire logic [15:0] motor_speed_in,
	output logic servo_ready_out,
	output logic power_stage_on_out,
	output logic brake_release_out,
	output logic ms_tick_out
);
	brake_seq_pkg::state_t s_r;
	brake_seq_pkg::state_t s_nxt;
	logic tick;
	logic stopping;
	logic fast;

	// write with lower halfword lanes, value clamped to its documented top
	function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel, input logic [15:0] top);
		logic [15:0] v;
		v = old;
		if (sel[0]) v[7:0] = d[7:0];
		if (sel[1]) v[15:8] = d[15:8];
		if (v > top) v = top;
		return v;
	endfunction : wr16

	assign tick = (s_r.tick_cnt == 16'(TICK_CYCLES - 1)); // [R15]
	assign stopping = !servo_enable_request_in || alarm_in; // [R5] [R16]
	assign fast = (motor_speed_in > s_r.cfg.standstill_speed_threshold); // [R7] [R14]

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick_cnt = tick ? 16'h0000 : s_r.tick_cnt + 16'h0001;
		if (tick && s_r.ms_cnt != 16'hffff) begin
			s_nxt.ms_cnt = s_r.ms_cnt + 16'h0001;
		end
		// bus slave: ack one cycle, dropped after it was given
		s_nxt.ack = wb_cyc_in && wb_stb_in && !s_r.ack;
		if (wb_cyc_in && wb_stb_in && !s_r.ack) begin
			s_nxt.rdata = 32'h00000000;
			case (wb_adr_in)
				brake_seq_pkg::ADR_STANDSTILL: s_nxt.rdata = {16'h0000, s_r.cfg.standstill_speed_threshold};
				brake_seq_pkg::ADR_HOLD: s_nxt.rdata = {16'h0000, s_r.cfg.standstill_brake_hold_time};
				brake_seq_pkg::ADR_WAIT: s_nxt.rdata = {16'h0000, s_r.cfg.running_brake_wait_limit};
				brake_seq_pkg::ADR_RUNSPD: s_nxt.rdata = {16'h0000, s_r.cfg.running_brake_speed};
				brake_seq_pkg::ADR_OPEN: s_nxt.rdata = {16'h0000, s_r.cfg.brake_open_delay};
				brake_seq_pkg::ADR_STATUS: s_nxt.rdata = {26'h0000000, s_r.state, s_r.brake_release,
					s_r.power_on, s_r.servo_ready};
				default: s_nxt.rdata = 32'h00000000;
			endcase
			if (wb_we_in) begin
				case (wb_adr_in)
					brake_seq_pkg::ADR_STANDSTILL: s_nxt.cfg.standstill_speed_threshold = wr16(
						s_r.cfg.standstill_speed_threshold, wb_dat_in, wb_sel_in,
						brake_seq_pkg::STANDSTILL_SPEED_MAX); // [R7]
					brake_seq_pkg::ADR_HOLD: s_nxt.cfg.standstill_brake_hold_time = wr16(
						s_r.cfg.standstill_brake_hold_time, wb_dat_in, wb_sel_in, brake_seq_pkg::HOLD_TIME_MAX); // [R8]
					brake_seq_pkg::ADR_WAIT: s_nxt.cfg.running_brake_wait_limit = wr16(
						s_r.cfg.running_brake_wait_limit, wb_dat_in, wb_sel_in, brake_seq_pkg::WAIT_LIMIT_MAX); // [R11]
					brake_seq_pkg::ADR_RUNSPD: s_nxt.cfg.running_brake_speed = wr16(
						s_r.cfg.running_brake_speed, wb_dat_in, wb_sel_in, brake_seq_pkg::RUN_BRAKE_SPEED_MAX); // [R12]
					brake_seq_pkg::ADR_OPEN: s_nxt.cfg.brake_open_delay = wr16(
						s_r.cfg.brake_open_delay, wb_dat_in, wb_sel_in, brake_seq_pkg::OPEN_DELAY_MAX); // [R9]
					default: ;
				endcase
			end
		end
		case (s_r.state)
			brake_seq_pkg::ST_OFF: begin
				s_nxt.servo_ready = 1'b0; // [R1]
				s_nxt.power_on = 1'b0;
				s_nxt.brake_release = 1'b0;
				if (!main_supply_in) begin
					s_nxt.ms_cnt = 16'h0000;
				end else if (s_r.ms_cnt >= 16'(READY_DELAY_MS)) begin
					s_nxt.state = brake_seq_pkg::ST_READY; // [R2]
					s_nxt.servo_ready = 1'b1;
				end
			end
			brake_seq_pkg::ST_READY: begin
				s_nxt.power_on = 1'b0;
				s_nxt.brake_release = 1'b0; // [R13]
				if (servo_enable_request_in && !alarm_in) begin
					s_nxt.state = brake_seq_pkg::ST_ON; // [R3] [R4]
					s_nxt.power_on = 1'b1;
					s_nxt.ms_cnt = 16'h0000; // [R15]
					s_nxt.tick_cnt = 16'h0000;
				end
			end
			brake_seq_pkg::ST_ON: begin
				if (!s_r.brake_release && s_r.ms_cnt >= s_r.cfg.brake_open_delay) begin
					s_nxt.brake_release = 1'b1; // [R9]
				end
				if (stopping) begin
					s_nxt.ms_cnt = 16'h0000; // [R15]
					s_nxt.tick_cnt = 16'h0000;
					if (fast) begin
						// brake never lifted yet: nothing left to time, so no wait blocks a re-enable
						s_nxt.state = s_r.brake_release ? brake_seq_pkg::ST_COAST : brake_seq_pkg::ST_READY; // [R10] [R14]
						s_nxt.power_on = 1'b0;
						s_nxt.brake_release = s_r.brake_release;
					end else if (alarm_in) begin
						// an alarm frees the motor at once, no holding current and no hold timing
						s_nxt.state = brake_seq_pkg::ST_READY; // [R16]
						s_nxt.power_on = 1'b0;
						s_nxt.brake_release = 1'b0;
					end else begin
						s_nxt.state = brake_seq_pkg::ST_HOLD; // [R8]
						s_nxt.brake_release = 1'b0;
					end
				end
			end
			brake_seq_pkg::ST_HOLD: begin
				s_nxt.brake_release = 1'b0;
				if (alarm_in) begin
					s_nxt.state = brake_seq_pkg::ST_READY; // [R5]
					s_nxt.power_on = 1'b0;
				end
				if (s_r.ms_cnt >= s_r.cfg.standstill_brake_hold_time) begin
					s_nxt.state = brake_seq_pkg::ST_READY; // [R8]
					s_nxt.power_on = 1'b0;
				end
			end
			brake_seq_pkg::ST_COAST: begin
				s_nxt.power_on = 1'b0;
				if (s_r.ms_cnt >= s_r.cfg.running_brake_wait_limit
					|| motor_speed_in <= s_r.cfg.running_brake_speed) begin
					s_nxt.state = brake_seq_pkg::ST_READY; // [R11]
					s_nxt.brake_release = 1'b0;
				end
			end
			default: begin
				s_nxt.state = brake_seq_pkg::ST_OFF;
			end
		endcase
		// losing main supply drops everything back to not ready
		if (!main_supply_in) begin
			s_nxt.state = brake_seq_pkg::ST_OFF; // [R1]
			// a short dip must not leave a stale count that makes ready come back early
			s_nxt.ms_cnt = 16'h0000; // [R2]
			s_nxt.servo_ready = 1'b0;
			s_nxt.power_on = 1'b0;
			s_nxt.brake_release = 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_r.cfg.standstill_speed_threshold <= brake_seq_pkg::STANDSTILL_SPEED_DEF;
			s_r.cfg.standstill_brake_hold_time <= brake_seq_pkg::HOLD_TIME_DEF;
			s_r.cfg.running_brake_wait_limit <= brake_seq_pkg::WAIT_LIMIT_DEF;
			s_r.cfg.running_brake_speed <= brake_seq_pkg::RUN_BRAKE_SPEED_DEF;
			s_r.cfg.brake_open_delay <= brake_seq_pkg::OPEN_DELAY_DEF;
			s_r.state <= brake_seq_pkg::ST_OFF;
			s_r.tick_cnt <= 16'h0000;
			s_r.ms_cnt <= 16'h0000;
			s_r.servo_ready <= 1'b0;
			s_r.power_on <= 1'b0;
			s_r.brake_release <= 1'b0;
			s_r.ack <= 1'b0;
			s_r.rdata <= 32'h00000000;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_dat_out = s_r.rdata;
	assign wb_ack_out = s_r.ack;
	assign servo_ready_out = s_r.servo_ready;
	assign power_stage_on_out = s_r.power_on;
	assign brake_release_out = s_r.brake_release; // [R13]
	assign ms_tick_out = tick;
endmodule : servo_enable_brake_sequencer
`default_nettype wire

// ### host_relay_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_relay_model (
	input wire logic clk_in,
	input wire logic power_req_in,
	input wire logic brake_release_in,
	output logic control_supply_out,
	output logic main_supply_out,
	output logic brake_free_out
);
	initial {control_supply_out, main_supply_out, brake_free_out} = 3'b000;
	always @(posedge clk_in) begin
		control_supply_out <= power_req_in;
		main_supply_out <= power_req_in & control_supply_out; // main never ahead of control
		brake_free_out <= brake_release_in; // energised coil lifts the brake
	end
endmodule : host_relay_model
`default_nettype wire

// ### brake_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module brake_seq_checker #(
	parameter int TICK_LAST = brake_seq_pkg::TICK_CYCLES - 1
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic main_supply_in,
	input wire logic servo_enable_request_in,
	input wire logic alarm_in,
	input wire logic servo_ready_out,
	input wire logic power_stage_on_out,
	input wire logic brake_release_out,
	input wire logic ms_tick_out
);
	logic [15:0] gap_r;
	logic seen_r;
	// first gap after reset is not judged, its start is the reset edge
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			gap_r <= 16'h0000;
			seen_r <= 1'b0;
		end else begin
			// the prescaler restarts only around powered cycles, so gaps are judged from the last of them
			gap_r <= (ms_tick_out || power_stage_on_out) ? 16'h0000 : gap_r + 16'h0001;
			seen_r <= seen_r | ms_tick_out;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	AST_NO_MAIN_READY: assert property (!main_supply_in |=> !servo_ready_out) else $error("ready without main");
	AST_READY_LATE: assert property ($rose(main_supply_in) |=> !servo_ready_out [*8]) else $error("ready early");
	AST_ON_NEEDS_READY: assert property ($rose(power_stage_on_out) |-> $past(servo_ready_out)) else $error("on early");
	AST_ENABLE_ON: assert property (servo_ready_out && servo_enable_request_in && !alarm_in && main_supply_in
		&& !power_stage_on_out && !brake_release_out |=> power_stage_on_out) else $error("enable ignored");
	AST_ALARM_FREES: assert property (alarm_in |=> !power_stage_on_out) else $error("alarm kept power");
	AST_MAIN_LOSS: assert property (!main_supply_in |=> !power_stage_on_out && !brake_release_out)
		else $error("outputs without main");
	AST_BRAKE_AFTER_ON: assert property ($rose(brake_release_out) |-> $past(power_stage_on_out))
		else $error("brake before current");
	AST_TICK_PULSE: assert property (ms_tick_out |=> !ms_tick_out) else $error("tick too long");
	AST_TICK_GAP: assert property (!seen_r || gap_r <= TICK_LAST) else $error("tick gap too long");
endmodule : brake_seq_checker
bind servo_enable_brake_sequencer brake_seq_checker #(.TICK_LAST(TICK_CYCLES - 1)) chk (.clk_in(clk_in),
	.sys_rst_in(sys_rst_in),
	.main_supply_in(main_supply_in), .servo_enable_request_in(servo_enable_request_in), .alarm_in(alarm_in),
	.servo_ready_out(servo_ready_out), .power_stage_on_out(power_stage_on_out),
	.brake_release_out(brake_release_out), .ms_tick_out(ms_tick_out));
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h00000000;
	logic power_req = 1'b0;
	logic req = 1'b0;
	logic alarm = 1'b0;
	logic [15:0] speed = 16'h0000;
	logic [31:0] rdat;
	logic ack, ready, power, brake, tick, brake_free, ctl_sup, main_sup;
	logic [31:0] exp_q[$];
	logic [15:0] v;
	int error_cnt = 0;
	int checked = 0;
	int n;
	int tot;
	localparam int TICK = 20;
	localparam int READY_MS = 10;
	localparam int HOLD_MS = 3;
	localparam int WAIT_MS = 4;
	localparam int OPEN_MS = 2;
	localparam logic [15:0] RUN_SPEED = 16'h07d0;
	logic [15:0] seq_t[5] = '{brake_seq_pkg::STANDSTILL_SPEED_DEF, 16'(HOLD_MS), 16'(WAIT_MS),
		brake_seq_pkg::RUN_BRAKE_SPEED_DEF, 16'(OPEN_MS)};
	logic [7:0] adr_t[5] = '{brake_seq_pkg::ADR_STANDSTILL, brake_seq_pkg::ADR_HOLD, brake_seq_pkg::ADR_WAIT,
		brake_seq_pkg::ADR_RUNSPD, brake_seq_pkg::ADR_OPEN};
	logic [15:0] def_t[5] = '{brake_seq_pkg::STANDSTILL_SPEED_DEF, brake_seq_pkg::HOLD_TIME_DEF,
		brake_seq_pkg::WAIT_LIMIT_DEF, brake_seq_pkg::RUN_BRAKE_SPEED_DEF, brake_seq_pkg::OPEN_DELAY_DEF};
	logic [15:0] max_t[5] = '{brake_seq_pkg::STANDSTILL_SPEED_MAX, brake_seq_pkg::HOLD_TIME_MAX,
		brake_seq_pkg::WAIT_LIMIT_MAX, brake_seq_pkg::RUN_BRAKE_SPEED_MAX, brake_seq_pkg::OPEN_DELAY_MAX};
	// short tick and ready delay keep the whole sequence inside a short run
	servo_enable_brake_sequencer #(.TICK_CYCLES(TICK), .READY_DELAY_MS(READY_MS)) uut (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h3), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.main_supply_in(main_sup), .servo_enable_request_in(req), .alarm_in(alarm), .motor_speed_in(speed),
		.servo_ready_out(ready), .power_stage_on_out(power), .brake_release_out(brake), .ms_tick_out(tick));
	host_relay_model partner (.clk_in(clk_in), .power_req_in(power_req), .brake_release_in(brake),
		.control_supply_out(ctl_sup), .main_supply_out(main_sup), .brake_free_out(brake_free));
	initial forever #12.5 clk_in = ~clk_in;
	task automatic complete_run();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// polls every edge; a level not reached within lim edges ends the run as a failure
	task automatic wait_st(input logic [2:0] want, input int lim, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk_in);
			cnt++;
		end while ({ready, power, brake} !== want && cnt < lim);
		if ({ready, power, brake} !== want) begin
			error_cnt++;
			$display("mismatch t=%0t got %h exp %h", $time, {ready, power, brake}, want);
			complete_run();
		end
	endtask : wait_st
	task automatic enable_seq(input logic [15:0] spd);
		int c;
		@(posedge clk_in);
		req <= 1'b1;
		speed <= spd;
		wait_st(3'h6, 8, c);
		cmp(c, 2);
		wait_st(3'h7, OPEN_MS * TICK + 8, c);
		cmp(c, OPEN_MS * TICK + 1);
		@(posedge clk_in);
		cmp({29'h0, ctl_sup, main_sup, brake_free}, 32'h7);
	endtask : enable_seq
	task automatic stop_seq(input logic by_alarm, input logic [2:0] mid, input logic [2:0] last, input int ms);
		int c;
		@(posedge clk_in);
		if (by_alarm) alarm <= 1'b1;
		else req <= 1'b0;
		wait_st(mid, 8, c);
		cmp(c, 2);
		wait_st(last, ms * TICK + 8, c);
		cmp(c, ms * TICK + 1);
		if (by_alarm) begin
			@(posedge clk_in);
			alarm <= 1'b0;
			req <= 1'b0;
		end
	endtask : stop_seq
	// reads only queue a note; the watcher below compares when ack shows
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		int k;
		k = 0;
		if (!w) exp_q.push_back(e);
		@(posedge clk_in);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin @(posedge clk_in); k++; end while (ack !== 1'b1 && k < 20);
		cyc <= 1'b0;
		if (k >= 20) begin error_cnt++; complete_run(); end
	endtask : bus
	always @(negedge clk_in) begin
		if (ack === 1'b1 && we === 1'b0) cmp(rdat, exp_q.size() ? exp_q.pop_front() : 32'hx);
	end
	initial begin
		void'($urandom(5));
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		for (int i = 0; i < 5; i++) bus(1'b0, adr_t[i], 32'h0, {16'h0, def_t[i]});
		bus(1'b0, brake_seq_pkg::ADR_STATUS, 32'h0, 32'h0);
		for (int i = 0; i < 5; i++) begin
			v = 16'($urandom_range(max_t[i]));
			bus(1'b1, adr_t[i], {16'($urandom), v}, 32'h0);
			bus(1'b0, adr_t[i], 32'h0, {16'h0, v});
			bus(1'b1, adr_t[i], 32'h0000ffff, 32'h0);
			bus(1'b0, adr_t[i], 32'h0, {16'h0, max_t[i]});
		end
		bus(1'b1, 8'h18, 32'h0000ffff, 32'h0);
		bus(1'b0, 8'h18, 32'h0, 32'h0);
		// no main supply yet: request and alarm must not move the stage
		req <= 1'b1;
		repeat (1000) begin
			@(posedge clk_in);
			alarm <= 1'($urandom);
			speed <= 16'($urandom);
			cmp({29'h0, ready, power, brake}, 32'h0);
		end
		@(posedge clk_in);
		alarm <= 1'b0;
		req <= 1'b0;
		power_req <= 1'b1;
		n = 0;
		do begin @(posedge clk_in); n++; end while (tick !== 1'b1 && n < TICK + 2);
		cmp({31'h0, tick}, 32'h1);
		tot = n;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
			cmp({29'h0, ready, power, brake}, 32'h0);
		end while (tick !== 1'b1 && n < TICK + 2);
		cmp(n, TICK);
		cmp({29'h0, ctl_sup, main_sup, brake_free}, 32'h6);
		tot += n;
		wait_st(3'h4, (READY_MS + 1) * TICK + 8, n);
		tot += n;
		cmp(32'(tot >= (READY_MS - 1) * TICK && tot <= READY_MS * TICK + 5), 32'h1);
		for (int i = 0; i < 5; i++) bus(1'b1, adr_t[i], {16'h0, seq_t[i]}, 32'h0);
		// speed equal to the threshold still counts as standing
		enable_seq(brake_seq_pkg::STANDSTILL_SPEED_DEF);
		stop_seq(1'b0, 3'h6, 3'h4, HOLD_MS);
		enable_seq(RUN_SPEED);
		stop_seq(1'b0, 3'h5, 3'h4, WAIT_MS);
		enable_seq(RUN_SPEED);
		stop_seq(1'b1, 3'h5, 3'h4, WAIT_MS);
		enable_seq(16'h0000);
		@(posedge clk_in);
		alarm <= 1'b1;
		wait_st(3'h4, 8, n);
		cmp(n, 2);
		@(posedge clk_in);
		alarm <= 1'b0;
		req <= 1'b0;
		enable_seq(RUN_SPEED);
		@(posedge clk_in);
		req <= 1'b0;
		wait_st(3'h5, 8, n);
		cmp(n, 2);
		speed <= brake_seq_pkg::RUN_BRAKE_SPEED_DEF;
		wait_st(3'h4, 8, n);
		cmp(n, 2);
		@(posedge clk_in);
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		bus(1'b0, adr_t[0], 32'h0, {16'h0, def_t[0]});
		bus(1'b0, adr_t[4], 32'h0, {16'h0, def_t[4]});
		bus(1'b0, brake_seq_pkg::ADR_STATUS, 32'h0, 32'h0);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
